//--- rtl/flcl_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Host writes zero into read config bits 15 to 1.
// - Pin configuration is B8h then code 00h to 03h.
// - Host keeps configuration code bits 7 to 2 at zero.
// - Host configures only when ready, checking the ready bit first.
// - Lock set is 60h then confirm at block address; refused when busy.
// - Host repeats a clear aborted by a voltage fault.
// - Erase-type confirm cycle carries D0h with a block address.
module flcl_ctrl #(
    parameter int MAX_RETRY = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire flcl_pkg::flcl_op_t cmd_op,
    input wire logic [flcl_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output flcl_pkg::flcl_rsp_t rsp_code,
    output logic [flcl_pkg::DATA_W-1:0] rsp_data,
    output logic [1:0] sts_mode,
    output logic sts_ready,
    output logic done_pulse,
    output logic [flcl_pkg::ADDR_W-1:0] f_addr,
    output logic [flcl_pkg::DATA_W-1:0] f_dq_o,
    input wire logic [flcl_pkg::DATA_W-1:0] f_dq_i,
    output logic f_dq_oe,
    output logic f_ce_n,
    output logic f_oe_n,
    output logic f_we_n,
    output logic power_down_input_n,
    input wire logic status_output_pin
);
    import flcl_pkg::*;

    // The retry counter is three bits wide
    if (MAX_RETRY < 0 || MAX_RETRY > 7) begin : g_retry_bad
        $error("MAX_RETRY must lie in 0..7");
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_CHK_W, S_CHK_R, S_W1, S_W2, S_POLL, S_CLRS, S_RD,
        S_EXIT
    } flcl_st_t;

    flcl_cyc_if cyc ();

    flcl_st_t st_r, st_nxt;
    flcl_op_t op_r, op_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt, caddr_r, caddr_nxt;
    logic [7:0] data_r, data_nxt, sr_r, sr_nxt, cw;
    logic [DATA_W-1:0] cwdata_r, cwdata_nxt;
    logic [2:0] retry_r, retry_nxt;
    logic issued_r, issued_nxt, req_r, req_nxt, wr_r, wr_nxt, cwr;
    logic ready_r, ready_nxt, rv_r, rv_nxt;
    flcl_rsp_t rc_r, rc_nxt;
    logic [DATA_W-1:0] rd_r, rd_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic prev_r, prev_nxt, sready_r, sready_nxt, dp_r, dp_nxt;
    logic rp_n_r, sr_fault;
    logic [ADDR_W-1:0] rcr_addr, ca;

    // Reserved bits 15..1 stay zero; only the mode bit is driven
    always_comb begin
        rcr_addr = '0;
        rcr_addr[RCR_MODE_BIT] = data_r[0];
    end

    assign sr_fault = cyc.rdata[SR_ERASE_ERR_BIT]
        | cyc.rdata[SR_PROG_ERR_BIT] | cyc.rdata[SR_PROGRAM_ENABLE_VOLTAGE_BIT]
        | cyc.rdata[SR_LOCK_BIT];

    // Byte and direction of the bus cycle owned by each state
    always_comb begin
        cw = CMD_READ_STATUS;
        cwr = 1'b1;
        ca = (op_r == OP_WRITE_RCR) ? rcr_addr : addr_r;
        case (st_r)
            S_CHK_W: cw = CMD_READ_STATUS;
            S_W1: begin
                case (op_r)
                    OP_CONFIG: cw = CMD_CONFIG;
                    OP_READ_ID: cw = CMD_READ_ID;
                    OP_CLEAR_STATUS: cw = CMD_CLEAR_STATUS;
                    OP_READ_ARRAY: cw = CMD_READ_ARRAY;
                    default: cw = CMD_LOCK_SETUP;
                endcase
            end
            S_W2: begin
                case (op_r)
                    OP_CONFIG: cw = data_r;
                    OP_LOCK_SET: cw = CMD_LOCK_SET_CONFIRM;
                    OP_LOCK_CLEAR: cw = CMD_LOCK_CLEAR_CONFIRM;
                    default: cw = CMD_RCR_CONFIRM;
                endcase
            end
            S_CLRS: cw = CMD_CLEAR_STATUS;
            S_EXIT: cw = CMD_READ_ARRAY;
            default: cwr = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        sr_nxt = sr_r;
        retry_nxt = retry_r;
        issued_nxt = issued_r;
        req_nxt = 1'b0;
        wr_nxt = wr_r;
        caddr_nxt = caddr_r;
        cwdata_nxt = cwdata_r;
        ready_nxt = ready_r;
        rv_nxt = 1'b0;
        rc_nxt = rc_r;
        rd_nxt = rd_r;
        mode_nxt = mode_r;
        if (st_r != S_IDLE && !issued_r) begin
            req_nxt = 1'b1;
            issued_nxt = 1'b1;
            wr_nxt = cwr;
            caddr_nxt = ca;
            cwdata_nxt = {8'h00, cw};
        end
        case (st_r)
            S_IDLE: begin
                // Ready rises on the first edge after reset
                ready_nxt = 1'b1;
                if (cmd_valid && ready_r) begin
                    op_nxt = cmd_op;
                    addr_nxt = cmd_addr;
                    data_nxt = cmd_data;
                    retry_nxt = 3'h0;
                    ready_nxt = 1'b0;
                    case (cmd_op)
                        OP_CONFIG: begin
                            if (cmd_data[7:2] != 6'h00) begin
                                rc_nxt = RSP_BAD_CODE;
                                rv_nxt = 1'b1;
                                ready_nxt = 1'b1;
                            end else begin
                                st_nxt = S_CHK_W;
                            end
                        end
                        OP_LOCK_SET, OP_LOCK_CLEAR,
                        OP_READ_STATUS: st_nxt = S_CHK_W;
                        default: st_nxt = S_W1;
                    endcase
                end
            end
            default: begin
                if (issued_r && cyc.done) begin
                    issued_nxt = 1'b0;
                    case (st_r)
                        S_CHK_W: st_nxt = S_CHK_R;
                        S_CHK_R: begin
                            sr_nxt = cyc.rdata[7:0];
                            if (op_r == OP_READ_STATUS) begin
                                rd_nxt = cyc.rdata;
                                rc_nxt = RSP_OK;
                                st_nxt = S_IDLE;
                            end else if (!cyc.rdata[SR_READY_BIT]) begin
                                // Refused after the 70h status read; no byte of the command itself reaches the device
                                rc_nxt = RSP_BUSY;
                                st_nxt = S_IDLE;
                            end else begin
                                st_nxt = S_W1;
                            end
                        end
                        S_W1: begin
                            if (op_r == OP_CLEAR_STATUS) begin
                                rc_nxt = RSP_OK;
                                st_nxt = S_IDLE;
                            end else if (op_r == OP_READ_ID
                                         || op_r == OP_READ_ARRAY) begin
                                st_nxt = S_RD;
                            end else begin
                                st_nxt = S_W2;
                            end
                        end
                        S_W2: begin
                            if (op_r == OP_LOCK_SET
                                || op_r == OP_LOCK_CLEAR) begin
                                st_nxt = S_POLL;
                            end else begin
                                if (op_r == OP_CONFIG) begin
                                    mode_nxt = data_r[1:0];
                                end
                                rc_nxt = RSP_OK;
                                st_nxt = S_IDLE;
                            end
                        end
                        S_POLL: begin
                            // Device answers status until ready is set
                            if (cyc.rdata[SR_READY_BIT]) begin
                                sr_nxt = cyc.rdata[7:0];
                                rd_nxt = cyc.rdata;
                                if (op_r == OP_LOCK_CLEAR && sr_fault
                                    && retry_r < 3'(MAX_RETRY)) begin
                                    retry_nxt = retry_r + 3'h1;
                                    st_nxt = S_CLRS;
                                end else begin
                                    rc_nxt = sr_fault ? RSP_DEV_ERR
                                                      : RSP_OK;
                                    st_nxt = S_IDLE;
                                end
                            end
                        end
                        S_CLRS: st_nxt = S_W1;
                        S_RD: begin
                            rd_nxt = cyc.rdata;
                            rc_nxt = RSP_OK;
                            st_nxt = (op_r == OP_READ_ID) ? S_EXIT : S_IDLE;
                        end
                        S_EXIT: st_nxt = S_IDLE;
                        default: st_nxt = S_IDLE;
                    endcase
                    if (st_nxt == S_IDLE) begin
                        rv_nxt = 1'b1;
                        ready_nxt = 1'b1;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Status pin watcher
    // ------------------------------------------------------------
    // Pulse mode: a low then high on the pin marks one completion.
    // Pulses shorter than a clock period may be missed.
    always_comb begin
        prev_nxt = status_output_pin;
        dp_nxt = (mode_r != STS_MODE_RESET) && !prev_r
                 && status_output_pin;
        sready_nxt = (mode_r == STS_MODE_RESET) ? status_output_pin
                                                : sready_r;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= S_IDLE;
            op_r <= OP_CONFIG;
            addr_r <= '0;
            data_r <= 8'h00;
            sr_r <= 8'h00;
            retry_r <= 3'h0;
            issued_r <= 1'b0;
            req_r <= 1'b0;
            wr_r <= 1'b0;
            caddr_r <= '0;
            cwdata_r <= '0;
            ready_r <= 1'b0;
            rv_r <= 1'b0;
            rc_r <= RSP_OK;
            rd_r <= '0;
            mode_r <= STS_MODE_RESET;
            prev_r <= 1'b1;
            sready_r <= 1'b0;
            dp_r <= 1'b0;
            rp_n_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            sr_r <= sr_nxt;
            retry_r <= retry_nxt;
            issued_r <= issued_nxt;
            req_r <= req_nxt;
            wr_r <= wr_nxt;
            caddr_r <= caddr_nxt;
            cwdata_r <= cwdata_nxt;
            ready_r <= ready_nxt;
            rv_r <= rv_nxt;
            rc_r <= rc_nxt;
            rd_r <= rd_nxt;
            mode_r <= mode_nxt;
            prev_r <= prev_nxt;
            sready_r <= sready_nxt;
            dp_r <= dp_nxt;
            rp_n_r <= 1'b1;
        end
    end

    assign cyc.req = req_r;
    assign cyc.wr = wr_r;
    assign cyc.addr = caddr_r;
    assign cyc.wdata = cwdata_r;

    flcl_bus_cycle u_cycle (
        .clk(clk),
        .nrst(nrst),
        .cyc(cyc.slave),
        .f_addr(f_addr),
        .f_dq_o(f_dq_o),
        .f_dq_i(f_dq_i),
        .f_dq_oe(f_dq_oe),
        .f_ce_n(f_ce_n),
        .f_oe_n(f_oe_n),
        .f_we_n(f_we_n)
    );

    assign cmd_ready = ready_r;
    assign rsp_valid = rv_r;
    assign rsp_code = rc_r;
    assign rsp_data = rd_r;
    assign sts_mode = mode_r;
    assign sts_ready = sready_r;
    assign done_pulse = dp_r;
    // Power-down input held low through reset restores level mode
    assign power_down_input_n = rp_n_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_cfg_code_clean: assert property (@(posedge clk) disable iff (!nrst)
        (req_r && st_r == S_W2 && op_r == OP_CONFIG)
        |-> cwdata_r[7:2] == 6'h00)
        else $error("reserved code bits sent");
    a_rcr_reserved: assert property (@(posedge clk) disable iff (!nrst)
        (req_r && op_r == OP_WRITE_RCR) |-> caddr_r[15:1] == 15'h0000)
        else $error("reserved read config bits sent");
    a_cfg_when_ready: assert property (@(posedge clk) disable iff (!nrst)
        (req_r && st_r == S_W1 && op_r == OP_CONFIG) |-> sr_r[7])
        else $error("configuration issued while busy");
    a_cfg_two_cycle: assert property (@(posedge clk) disable iff (!nrst)
        (req_r && st_r == S_W1 && op_r == OP_CONFIG)
        |-> ##[1:30] (req_r && cwdata_r[7:0] == data_r))
        else $error("configuration code not sent");
    a_lock_set_pair: assert property (@(posedge clk) disable iff (!nrst)
        (req_r && st_r == S_W1 && op_r == OP_LOCK_SET)
        |-> sr_r[7] ##[1:30] (req_r && caddr_r == addr_r
            && cwdata_r[7:0] == CMD_LOCK_SET_CONFIRM))
        else $error("lock set confirm missing");
    a_clear_confirm: assert property (@(posedge clk) disable iff (!nrst)
        (req_r && st_r == S_W1 && op_r == OP_LOCK_CLEAR)
        |-> ##[1:30] (req_r && caddr_r == addr_r
            && cwdata_r[7:0] == CMD_LOCK_CLEAR_CONFIRM))
        else $error("clear confirm missing");
    a_clear_retry: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == S_POLL && cyc.done && op_r == OP_LOCK_CLEAR
         && cyc.rdata[SR_READY_BIT] && sr_fault
         && retry_r < 3'(MAX_RETRY)) |=> st_r == S_CLRS ##[1:30] st_r == S_W1)
        else $error("aborted clear not repeated");
    a_mode_update: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == S_W2 && cyc.done && op_r == OP_CONFIG)
        |=> mode_r == $past(data_r[1:0]) && rsp_valid)
        else $error("pin mode not tracked");
    a_busy_refused: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == S_CHK_R && cyc.done && !cyc.rdata[SR_READY_BIT]
         && op_r != OP_READ_STATUS)
        |=> rsp_valid && rsp_code == RSP_BUSY && $stable(mode_r))
        else $error("busy refusal wrong");
endmodule

//--- rtl/flcl_pkg.sv
package flcl_pkg;
    // ------------------------------------------------------------
    // Bus and clock
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int WE_LOW_NS = 70;
    localparam int OE_ACCESS_NS = 120;
    // Least times round up to whole cycles
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int OE_ACCESS_CYC = (OE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] WE_LOW_CNT = 3'(WE_LOW_CYC - 1);
    localparam logic [2:0] OE_ACCESS_CNT = 3'(OE_ACCESS_CYC - 1);

    // ------------------------------------------------------------
    // Command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_CONFIG = 8'hb8;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_SET_CONFIRM = 8'h01;
    localparam logic [7:0] CMD_LOCK_CLEAR_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_RCR_CONFIRM = 8'h03;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SR_READY_BIT = 7;
    localparam int SR_ERASE_ERR_BIT = 5;
    localparam int SR_PROG_ERR_BIT = 4;
    localparam int SR_PROGRAM_ENABLE_VOLTAGE_BIT = 3;
    localparam int SR_LOCK_BIT = 1;
    localparam int RCR_MODE_BIT = 16;
    localparam int CODE_ERASE_BIT = 0;
    localparam int CODE_PROG_BIT = 1;
    localparam logic [1:0] STS_MODE_RESET = 2'h0;

    typedef enum logic [2:0] {
        OP_CONFIG, OP_LOCK_SET, OP_LOCK_CLEAR, OP_READ_ID,
        OP_WRITE_RCR, OP_CLEAR_STATUS, OP_READ_STATUS, OP_READ_ARRAY
    } flcl_op_t;

    typedef enum logic [1:0] {
        RSP_OK, RSP_BUSY, RSP_BAD_CODE, RSP_DEV_ERR
    } flcl_rsp_t;
endpackage

//--- rtl/flcl_cyc_if.sv
`timescale 1ns/1ps
interface flcl_cyc_if;
    import flcl_pkg::*;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    modport master (output req, wr, addr, wdata, input rdata, done);
    modport slave (input req, wr, addr, wdata, output rdata, done);
endinterface

//--- rtl/flcl_bus_cycle.sv
`timescale 1ns/1ps
module flcl_bus_cycle (
    input wire logic clk,
    input wire logic nrst,
    flcl_cyc_if.slave cyc,
    output logic [flcl_pkg::ADDR_W-1:0] f_addr,
    output logic [flcl_pkg::DATA_W-1:0] f_dq_o,
    input wire logic [flcl_pkg::DATA_W-1:0] f_dq_i,
    output logic f_dq_oe,
    output logic f_ce_n,
    output logic f_oe_n,
    output logic f_we_n
);
    import flcl_pkg::*;

    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} flcl_cst_t;

    flcl_cst_t st_r, st_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] dq_r, dq_nxt, rd_r, rd_nxt;
    logic oe_r, oe_nxt, ce_n_r, ce_n_nxt;
    logic oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, done_r, done_nxt;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        addr_nxt = addr_r;
        dq_nxt = dq_r;
        rd_nxt = rd_r;
        oe_nxt = oe_r;
        ce_n_nxt = ce_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        done_nxt = 1'b0;
        case (st_r)
            C_IDLE: begin
                if (cyc.req) begin
                    wr_nxt = cyc.wr;
                    addr_nxt = cyc.addr;
                    dq_nxt = cyc.wdata;
                    oe_nxt = cyc.wr;
                    ce_n_nxt = 1'b0;
                    st_nxt = C_SETUP;
                end
            end
            C_SETUP: begin
                // Only single reads: each access is one full cycle
                if (wr_r) begin
                    we_n_nxt = 1'b0;
                    cnt_nxt = WE_LOW_CNT;
                end else begin
                    oe_n_nxt = 1'b0;
                    cnt_nxt = OE_ACCESS_CNT;
                end
                st_nxt = C_STROBE;
            end
            C_STROBE: begin
                if (cnt_r == 3'h0) begin
                    if (!wr_r) begin
                        rd_nxt = f_dq_i;
                    end
                    we_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    st_nxt = C_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            C_HOLD: begin
                ce_n_nxt = 1'b1;
                oe_nxt = 1'b0;
                done_nxt = 1'b1;
                st_nxt = C_IDLE;
            end
            default: st_nxt = C_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= C_IDLE;
            cnt_r <= 3'h0;
            wr_r <= 1'b0;
            addr_r <= '0;
            dq_r <= '0;
            rd_r <= '0;
            oe_r <= 1'b0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            dq_r <= dq_nxt;
            rd_r <= rd_nxt;
            oe_r <= oe_nxt;
            ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            done_r <= done_nxt;
        end
    end

    assign f_addr = addr_r;
    assign f_dq_o = dq_r;
    assign f_dq_oe = oe_r;
    assign f_ce_n = ce_n_r;
    assign f_oe_n = oe_n_r;
    assign f_we_n = we_n_r;
    assign cyc.rdata = rd_r;
    assign cyc.done = done_r;

    a_we_width: assert property (@(posedge clk) disable iff (!nrst)
        $fell(f_we_n) |-> !f_we_n [*2] ##1 f_we_n)
        else $error("write strobe width wrong");
    a_oe_width: assert property (@(posedge clk) disable iff (!nrst)
        $fell(f_oe_n) |-> !f_oe_n [*3] ##1 f_oe_n)
        else $error("read strobe width wrong");
    a_dq_dir: assert property (@(posedge clk) disable iff (!nrst)
        (!f_we_n |-> f_dq_oe) and (!f_oe_n |-> !f_dq_oe))
        else $error("data direction wrong");
endmodule

//--- testbench/flcl_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash: command latch, status, lock bits, status pin
module flcl_flash_model (
    input wire logic clk,
    input wire logic [22:0] f_addr,
    input wire logic [15:0] f_dq_o,
    input wire logic f_ce_n,
    input wire logic f_oe_n,
    input wire logic f_we_n,
    input wire logic power_down_input_n,
    input wire logic hold_busy,
    input wire logic program_enable_voltage_ok,
    output logic [15:0] f_dq_i,
    output logic status_output_pin
);
    logic [7:0] sr = '0, prev = 8'hff, md = 8'hff;
    logic [1:0] cfg = '0;
    logic rm = 0;
    logic [63:0] lk = '0;
    logic [15:0] last = '0;
    int bsy = 0, pl = 0;
    wire rdy = bsy == 0 && !hold_busy;
    wire [7:0] d = f_dq_o[7:0];
    wire [15:0] rd = md == 8'h70 ? {8'h0, rdy, sr[6:0]} :
        md != 8'h90 ? f_addr[15:0] ^ (rm ? 16'hc3c3 : 16'h3c3c) :
        f_addr[8] ? {f_addr[7:0], 8'ha5} :
        {15'h0, lk[f_addr[22:17]]};
    // Released bus shows the inverse so a stale sample cannot pass
    assign f_dq_i = !f_ce_n && !f_oe_n ? rd : ~last;
    assign status_output_pin = cfg == 0 ? rdy : pl == 0;
    always @(posedge f_we_n) if (f_ce_n === 0) begin
        if (prev == 8'hb8) begin
            if (d[7:2] != 0) sr[5:4] = 2'h3;
            else cfg = d[1:0];
            prev = 8'hff;
        end else if (prev == 8'h60) begin
            if (d == 8'h03) rm = f_addr[16];
            else if (rdy) begin
                md = 8'h70;
                bsy = 20;
                if (!program_enable_voltage_ok) sr[5:3] = {d == 8'hd0, d != 8'hd0, 1'b1};
                else if (d == 8'h01) lk[f_addr[22:17]] = 1;
                else lk = '0;
            end
            prev = 8'hff;
        end else begin
            prev = d;
            if (d == 8'h50) sr[5:3] = '0;
            if (d == 8'h70 || d == 8'h90 || d == 8'hff) md = d;
        end
    end
    always @(posedge clk) begin
        if (!power_down_input_n) cfg = '0;
        if (pl > 0) pl--;
        if (bsy == 1 && cfg != 0) pl = 6;
        if (bsy > 0) bsy--;
        if (!f_ce_n && !f_oe_n) last = rd;
    end
endmodule

//--- testbench/flash_config_lock_commands_tb.sv
`timescale 1ns/1ps
module flash_config_lock_commands_tb;
    import flcl_pkg::*;
    typedef struct {
        flcl_op_t op;
        logic [22:0] a;
        logic [7:0] d;
        flcl_rsp_t c;
        logic [1:0] m;
        logic [16:0] x;
    } flcl_row_t;
    logic clk = 0, nrst = 0, cmd_valid = 0, hold_busy = 0, program_enable_voltage_ok = 1;
    flcl_op_t cmd_op = OP_READ_STATUS;
    flcl_rsp_t rsp_code;
    logic [22:0] cmd_addr = '0, f_addr;
    logic [7:0] cmd_data = '0;
    logic [15:0] rsp_data, f_dq_o, f_dq_i, npl = '0;
    logic [1:0] sts_mode;
    logic cmd_ready, rsp_valid, sts_ready, done_pulse, f_dq_oe, f_ce_n;
    logic f_oe_n, f_we_n, power_down_input_n, status_output_pin;
    int err_count = 0, n_tests = 0, cyc = 0;
    flcl_row_t rows [15] = '{
        '{OP_CONFIG, '0, 8'h01, RSP_OK, 2'h1, '0},
        '{OP_CONFIG, '0, 8'h02, RSP_OK, 2'h2, '0},
        '{OP_CONFIG, '0, 8'h04, RSP_BAD_CODE, 2'h2, '0},
        '{OP_CONFIG, '0, 8'h03, RSP_OK, 2'h3, '0},
        '{OP_LOCK_SET, 23'h020000, '0, RSP_OK, 2'h3, '0},
        '{OP_READ_ID, 23'h020000, '0, RSP_OK, 2'h3, 17'h10001},
        '{OP_READ_ID, '0, '0, RSP_OK, 2'h3, 17'h10000},
        '{OP_READ_ID, 23'h000181, '0, RSP_OK, 2'h3, 17'h181a5},
        '{OP_LOCK_CLEAR, 23'h020000, '0, RSP_OK, 2'h3, '0},
        '{OP_READ_ID, 23'h020000, '0, RSP_OK, 2'h3, 17'h10000},
        '{OP_READ_STATUS, '0, '0, RSP_OK, 2'h3, 17'h10080},
        '{OP_CONFIG, '0, 8'h00, RSP_OK, 2'h0, '0},
        '{OP_READ_ARRAY, 23'h001234, '0, RSP_OK, 2'h0, 17'h12e08},
        '{OP_WRITE_RCR, '0, 8'h01, RSP_OK, 2'h0, '0},
        '{OP_READ_ARRAY, 23'h001234, '0, RSP_OK, 2'h0, 17'h1d1f7}};
    flcl_ctrl i_flcl_ctrl (.*);
    flcl_flash_model i_flcl_flash_model (.*);
    initial forever #20 clk = ~clk;
    always @(negedge clk) if (done_pulse === 1) npl++;
    always @(posedge clk) if (++cyc == 20000) begin
        err_count++;
        stop_test();
    end
    task stop_test;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, s);
        n_tests++;
        if (e !== s) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
            err_count++;
        end
    endtask
    task cmd(input flcl_op_t o, input logic [22:0] a,
        input logic [7:0] d, input flcl_rsp_t c);
        @(posedge clk) #1 cmd_valid = 1;
        cmd_op = o;
        cmd_addr = a;
        cmd_data = d;
        do @(negedge clk); while (cmd_ready !== 1);
        @(posedge clk) #1 cmd_valid = 0;
        do @(negedge clk); while (rsp_valid !== 1);
        chk("rsp_code", 16'(c), 16'(rsp_code));
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        foreach (rows[i]) begin
            cmd(rows[i].op, rows[i].a, rows[i].d, rows[i].c);
            chk("sts_mode", rows[i].m, sts_mode);
            if (rows[i].x[16]) chk("data", rows[i].x[15:0], rsp_data);
        end
        chk("pulses", 16'h2, npl);
        program_enable_voltage_ok = 0;
        cmd(OP_LOCK_SET, 23'h040000, '0, RSP_DEV_ERR);
        program_enable_voltage_ok = 1;
        cmd(OP_READ_STATUS, '0, '0, RSP_OK);
        chk("status", 16'h0098, rsp_data);
        cmd(OP_CLEAR_STATUS, '0, '0, RSP_OK);
        cmd(OP_LOCK_SET, 23'h020000, '0, RSP_OK);
        program_enable_voltage_ok = 0;
        cmd(OP_LOCK_CLEAR, 23'h020000, '0, RSP_DEV_ERR);
        program_enable_voltage_ok = 1;
        cmd(OP_CLEAR_STATUS, '0, '0, RSP_OK);
        cmd(OP_READ_ID, 23'h020000, '0, RSP_OK);
        chk("lock kept", 16'h1, rsp_data);
        cmd(OP_READ_ID, 23'h040000, '0, RSP_OK);
        chk("lock", '0, rsp_data);
        hold_busy = 1;
        cmd(OP_CONFIG, '0, 8'h01, RSP_BUSY);
        chk("busy mode", '0, sts_mode);
        chk("sts_ready", '0, sts_ready);
        hold_busy = 0;
        cmd(OP_CONFIG, '0, 8'h03, RSP_OK);
        chk("sts_ready", 16'h1, sts_ready);
        @(posedge clk) #1 nrst = 0;
        @(posedge clk) chk("reset mode", '0, sts_mode);
        chk("pd low", '0, power_down_input_n);
        chk("ready low", '0, cmd_ready);
        #1 nrst = 1;
        repeat (2) @(negedge clk);
        chk("pd high", 16'h1, power_down_input_n);
        chk("ready high", 16'h1, cmd_ready);
        cmd(OP_READ_STATUS, '0, '0, RSP_OK);
        chk("status", 16'h0080, rsp_data);
        stop_test();
    end
endmodule
